// file: rtl/drvfb_map.vh
// Purpose: Register map, field positions and codes of the fieldbus bit/word map
// Assumes: 32-bit AXI4-Lite words, byte addresses
// Notes: Selection codes are four-bit fields
`ifndef DRVFB_MAP_VH
`define DRVFB_MAP_VH

`define DRVFB_CMD_BITS 8'h00
`define DRVFB_STAT_BITS 8'h04
`define DRVFB_MON_CODE 8'h08
`define DRVFB_SET_FREQ 8'h0C
`define DRVFB_CMD_CODE 8'h10
`define DRVFB_WR_DATA 8'h14
`define DRVFB_MON_DATA 8'h18
`define DRVFB_OUT_FREQ 8'h1C
`define DRVFB_RESP_CODE 8'h20
`define DRVFB_RD_DATA 8'h24
`define DRVFB_AGREE_W 8'h28
`define DRVFB_IN_SEL 8'h2C
`define DRVFB_OUT_SEL 8'h30
`define DRVFB_FREQ_REF 8'h34

// Command bit positions
`define DRVFB_Y_FWD 0
`define DRVFB_Y_REV 1
`define DRVFB_Y_MI3 2
`define DRVFB_Y_MI7 6
`define DRVFB_Y_OFF 9
`define DRVFB_Y_EXTF 10
`define DRVFB_Y_MON 12
`define DRVFB_Y_FVOL 13
`define DRVFB_Y_FNV 14
`define DRVFB_Y_EXEC 15
`define DRVFB_Y_ALLOC 25
`define DRVFB_Y_ERST 26
// Writable command bits; the rest are ignored
`define DRVFB_CMD_MASK 32'h0600_F67F

// Status bit positions
`define DRVFB_X_FWD 0
`define DRVFB_X_REV 1
`define DRVFB_X_MOUT 2
`define DRVFB_X_AGREE 3
`define DRVFB_X_STALL 4
`define DRVFB_X_OPTA 6
`define DRVFB_X_OPTB 7
`define DRVFB_X_MON 12
`define DRVFB_X_FVOL 13
`define DRVFB_X_FNV 14
`define DRVFB_X_EXEC 15
`define DRVFB_X_ALLOC 25
`define DRVFB_X_ERR 26
`define DRVFB_X_READY 27

// Input function codes
`define DRVFB_IF_EXTF 4'h3
`define DRVFB_IF_FRST 4'h5
`define DRVFB_IF_MS1 4'h6
`define DRVFB_IF_MS2 4'h7
`define DRVFB_IF_MS3 4'h8
`define DRVFB_IF_JOG 4'hA
`define DRVFB_IF_INCH 4'hB
// Output function codes
`define DRVFB_OF_FAULT 4'h0
`define DRVFB_OF_RUN 4'h1
`define DRVFB_OF_FDET 4'h4
`define DRVFB_OF_READY 4'hD

// Allocation tables: inputs 3..7 and outputs 1..3, one nibble each
`define DRVFB_IN_SEL_RST 20'hA_7653
`define DRVFB_IN_SEL_ALT 20'hB_A876
`define DRVFB_OUT_SEL_RST 12'h01D
`define DRVFB_OUT_SEL_ALT 12'h041
`define DRVFB_AGREE_RST 16'h00C8
`define DRVFB_FDET_ALT 16'h0258

`define DRVFB_RESP_OK 2'b00
`define DRVFB_RESP_SLVERR 2'b10

`endif

// file: rtl/drvfb_top.v
// Purpose: Cyclic fieldbus bit/word map of a motor drive behind AXI4-Lite
// Assumes: Drive-side status arrives synchronous to clk_sys_i
// Notes: Operation
// Operation
// - Forward-running bit follows forward rotation
// - Reverse-running bit follows reverse rotation
// - Speed agree within agree-width band
// - Stall bit while stall prevention acts
// - Comm output bit by select, default ready
// - Two opto terminal states reported
// - Monitoring bit high while refreshing monitor data
// - Volatile set done after main frequency applied
// - Nonvolatile set done after store and apply
// - Execution done only after command finishes
// - Allocation-changed bit after alternate allocation
// - Error bit on any drive fault
// - Station ready while run enabled and no error
// - Run bits high run, low stop
// - Inputs five to seven from comm only
// - Inputs three, four routed to selected functions
// - Output-off coasts; release resumes running
// - External fault bit trips and coasts
// - Monitor request copies selected quantity
// - Volatile set loads main speed frequency
// - Nonvolatile reference kept, used at power-up
// - Execution request runs current command code
`timescale 1ns/1ps
`include "drvfb_map.vh"

module drvfb_top #(
    parameter FW = 16
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire running_fwd_i,
    input wire running_rev_i,
    input wire [FW-1:0] output_freq_i,
    input wire stall_active_i,
    input wire drive_fault_i,
    input wire run_enabled_i,
    input wire [FW-1:0] monitor_value_i,
    input wire [FW-1:0] nv_freq_i,
    input wire nv_ack_i,
    input wire cmd_done_i,
    input wire [FW-1:0] cmd_resp_i,
    input wire [FW-1:0] cmd_read_i,
    output reg fwd_run_o,
    output reg rev_run_o,
    output reg coast_o,
    output reg fault_reset_o,
    output reg [2:0] multi_step_o,
    output reg jog_o,
    output reg inch_o,
    output reg opto_terminal_a_o,
    output reg opto_terminal_b_o,
    output reg [FW-1:0] main_freq_o,
    output reg [FW-1:0] monitor_sel_o,
    output reg nv_store_o,
    output reg [FW-1:0] freq_ref_o,
    output reg cmd_start_o,
    output reg [FW-1:0] cmd_code_o,
    output reg [FW-1:0] cmd_data_o
);

    // Output function of a selection code
    function out_func;
        input [3:0] sel;
        input fault;
        input run;
        input fdet;
        input ready;
        begin
            case (sel)
                `DRVFB_OF_FAULT: out_func = fault;
                `DRVFB_OF_RUN: out_func = run;
                `DRVFB_OF_FDET: out_func = fdet;
                `DRVFB_OF_READY: out_func = ready;
                default: out_func = 1'b0;
            endcase
        end
    endfunction

    // Any of inputs 3..7 selected for a code and high
    function in_hit;
        input [3:0] code;
        input [19:0] sels;
        input [4:0] bits;
        integer k;
        begin
            in_hit = 1'b0;
            for (k = 0; k < 5; k = k + 1) begin
                if (sels[4*k +: 4] == code && bits[k])
                    in_hit = 1'b1;
            end
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k])
                    merge[8*k +: 8] = nw[8*k +: 8];
            end
        end
    endfunction

    reg [31:0] cmd_ff;
    reg [FW-1:0] monitor_code_word_ff, set_freq_word_ff;
    reg [FW-1:0] command_code_word_ff, write_data_word_ff;
    reg [FW-1:0] monitor_data_word_ff, response_code_word_ff, read_data_word_ff;
    reg [FW-1:0] agree_width_const_ff, freq_reference_const_ff;
    reg [19:0] in_sel_ff;
    reg [11:0] out_sel_ff;
    reg alloc_ff, ext_fault_ff, boot_ff;
    reg monitor_busy_conf_ff, freq_volatile_done_ff, freq_nonvolatile_done_ff;
    reg cmd_exec_done_ff, nv_wait_ff, exec_wait_ff;
    reg [31:0] stat_ff;

    // AXI write and read channel state
    reg aw_ff, w_ff, bvalid_ff, rvalid_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff, rdata_ff;
    reg [3:0] wstrb_ff;
    reg [1:0] bresp_ff, rresp_ff;

    wire fwd_run_cmd = cmd_ff[`DRVFB_Y_FWD];
    wire rev_run_cmd = cmd_ff[`DRVFB_Y_REV];
    wire [4:0] multi_in_cmd = cmd_ff[`DRVFB_Y_MI7:`DRVFB_Y_MI3];
    wire output_off_cmd = cmd_ff[`DRVFB_Y_OFF];
    wire ext_fault_cmd = cmd_ff[`DRVFB_Y_EXTF];
    wire monitor_req = cmd_ff[`DRVFB_Y_MON];
    wire freq_volatile_req = cmd_ff[`DRVFB_Y_FVOL];
    wire freq_nonvolatile_req = cmd_ff[`DRVFB_Y_FNV];
    wire cmd_exec_req = cmd_ff[`DRVFB_Y_EXEC];
    wire alloc_req = cmd_ff[`DRVFB_Y_ALLOC];
    wire err_reset_cmd = cmd_ff[`DRVFB_Y_ERST];

    // Alternate table replaces the programmed one once switched
    wire [19:0] in_sel = alloc_ff ? `DRVFB_IN_SEL_ALT : in_sel_ff;
    wire [11:0] out_sel = alloc_ff ? `DRVFB_OUT_SEL_ALT : out_sel_ff;
    wire [FW-1:0] fdet_level = alloc_ff ? `DRVFB_FDET_ALT : {FW{1'b0}};

    // Inputs five to seven exist only as command bits
    wire mf_ext_fault = in_hit(`DRVFB_IF_EXTF, in_sel, multi_in_cmd);
    wire mf_fault_reset = in_hit(`DRVFB_IF_FRST, in_sel, multi_in_cmd);
    wire comm_external_fault = ext_fault_cmd | mf_ext_fault;
    wire error_now = drive_fault_i | ext_fault_ff;
    wire running = running_fwd_i | running_rev_i;

    wire [FW-1:0] freq_diff = (output_freq_i > main_freq_o) ?
        (output_freq_i - main_freq_o) : (main_freq_o - output_freq_i);
    wire speed_agree = freq_diff <= agree_width_const_ff;
    wire ready_now = run_enabled_i & ~error_now;
    wire fdet = running & (output_freq_i >= fdet_level);
    wire opto_a_now = out_func(out_sel[7:4], error_now, running, fdet, ready_now);
    wire opto_b_now = out_func(out_sel[11:8], error_now, running, fdet, ready_now);

    // Drive-side controls
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            fwd_run_o <= 1'b0;
            rev_run_o <= 1'b0;
            coast_o <= 1'b0;
            fault_reset_o <= 1'b0;
            multi_step_o <= 3'b000;
            jog_o <= 1'b0;
            inch_o <= 1'b0;
            ext_fault_ff <= 1'b0;
            opto_terminal_a_o <= 1'b0;
            opto_terminal_b_o <= 1'b0;
        end else begin
            // Output-off or external fault forces coast; runs resume on output-off release, or after an error reset clears the fault
            coast_o <= output_off_cmd | ext_fault_ff;
            fwd_run_o <= fwd_run_cmd & ~output_off_cmd & ~ext_fault_ff;
            rev_run_o <= rev_run_cmd & ~output_off_cmd & ~ext_fault_ff;
            fault_reset_o <= err_reset_cmd | mf_fault_reset;
            multi_step_o <= {in_hit(`DRVFB_IF_MS3, in_sel, multi_in_cmd),
                             in_hit(`DRVFB_IF_MS2, in_sel, multi_in_cmd),
                             in_hit(`DRVFB_IF_MS1, in_sel, multi_in_cmd)};
            jog_o <= in_hit(`DRVFB_IF_JOG, in_sel, multi_in_cmd);
            inch_o <= in_hit(`DRVFB_IF_INCH, in_sel, multi_in_cmd);
            // Trip wins over a reset in the same cycle
            if (comm_external_fault)
                ext_fault_ff <= 1'b1;
            else if (err_reset_cmd | mf_fault_reset)
                ext_fault_ff <= 1'b0;
            opto_terminal_a_o <= opto_a_now;
            opto_terminal_b_o <= opto_b_now;
        end
    end

    // Request and confirmation handshakes
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_freq_o <= {FW{1'b0}};
            freq_reference_const_ff <= {FW{1'b0}};
            boot_ff <= 1'b1;
            monitor_sel_o <= {FW{1'b0}};
            monitor_data_word_ff <= {FW{1'b0}};
            monitor_busy_conf_ff <= 1'b0;
            freq_volatile_done_ff <= 1'b0;
            freq_nonvolatile_done_ff <= 1'b0;
            nv_wait_ff <= 1'b0;
            nv_store_o <= 1'b0;
            freq_ref_o <= {FW{1'b0}};
            cmd_exec_done_ff <= 1'b0;
            exec_wait_ff <= 1'b0;
            cmd_start_o <= 1'b0;
            cmd_code_o <= {FW{1'b0}};
            cmd_data_o <= {FW{1'b0}};
            response_code_word_ff <= {FW{1'b0}};
            read_data_word_ff <= {FW{1'b0}};
        end else begin
            nv_store_o <= 1'b0;
            cmd_start_o <= 1'b0;
            boot_ff <= 1'b0;
            // Stored reference becomes the speed at power-up
            if (boot_ff) begin
                freq_reference_const_ff <= nv_freq_i;
                main_freq_o <= nv_freq_i;
            end
            // Monitor: copy each cycle while requested, busy flag marks it
            monitor_sel_o <= monitor_code_word_ff;
            if (monitor_req)
                monitor_data_word_ff <= monitor_value_i;
            monitor_busy_conf_ff <= monitor_req;
            // Volatile set
            if (!freq_volatile_req)
                freq_volatile_done_ff <= 1'b0;
            else if (!freq_volatile_done_ff && !boot_ff) begin
                main_freq_o <= set_freq_word_ff;
                freq_volatile_done_ff <= 1'b1;
            end
            // Nonvolatile set waits for the store to be acknowledged
            if (!freq_nonvolatile_req) begin
                freq_nonvolatile_done_ff <= 1'b0;
            end else if (nv_wait_ff) begin
                if (nv_ack_i) begin
                    nv_wait_ff <= 1'b0;
                    freq_nonvolatile_done_ff <= 1'b1;
                end
            end else if (!freq_nonvolatile_done_ff && !boot_ff) begin
                freq_reference_const_ff <= set_freq_word_ff;
                main_freq_o <= set_freq_word_ff;
                freq_ref_o <= set_freq_word_ff;
                nv_store_o <= 1'b1;
                nv_wait_ff <= 1'b1;
            end
            // Command execution; a drop mid-run still waits for the end
            if (exec_wait_ff) begin
                if (cmd_done_i) begin
                    exec_wait_ff <= 1'b0;
                    response_code_word_ff <= cmd_resp_i;
                    read_data_word_ff <= cmd_read_i;
                    cmd_exec_done_ff <= cmd_exec_req;
                end
            end else if (!cmd_exec_req) begin
                cmd_exec_done_ff <= 1'b0;
            end else if (!cmd_exec_done_ff) begin
                cmd_code_o <= command_code_word_ff;
                cmd_data_o <= write_data_word_ff;
                cmd_start_o <= 1'b1;
                exec_wait_ff <= 1'b1;
            end
        end
    end

    // Status word; unused and reserved bits stay zero
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            stat_ff <= 32'h0000_0000;
        end else begin
            stat_ff <= 32'h0000_0000;
            stat_ff[`DRVFB_X_FWD] <= running_fwd_i;
            stat_ff[`DRVFB_X_REV] <= running_rev_i;
            stat_ff[`DRVFB_X_MOUT] <= out_func(out_sel[3:0], error_now, running,
                                               fdet, ready_now);
            stat_ff[`DRVFB_X_AGREE] <= speed_agree;
            stat_ff[`DRVFB_X_STALL] <= stall_active_i;
            stat_ff[`DRVFB_X_OPTA] <= opto_a_now;
            stat_ff[`DRVFB_X_OPTB] <= opto_b_now;
            stat_ff[`DRVFB_X_MON] <= monitor_busy_conf_ff;
            stat_ff[`DRVFB_X_FVOL] <= freq_volatile_done_ff;
            stat_ff[`DRVFB_X_FNV] <= freq_nonvolatile_done_ff;
            stat_ff[`DRVFB_X_EXEC] <= cmd_exec_done_ff;
            stat_ff[`DRVFB_X_ALLOC] <= alloc_ff;
            stat_ff[`DRVFB_X_ERR] <= error_now;
            stat_ff[`DRVFB_X_READY] <= ready_now;
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    assign s_axi_awready = ~aw_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_ff & ~bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    wire wr_go = aw_ff & w_ff & ~bvalid_ff;
    wire [31:0] wd = merge(32'h0000_0000, wdata_ff, wstrb_ff);

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `DRVFB_RESP_OK;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            cmd_ff <= 32'h0000_0000;
            monitor_code_word_ff <= {FW{1'b0}};
            set_freq_word_ff <= {FW{1'b0}};
            command_code_word_ff <= {FW{1'b0}};
            write_data_word_ff <= {FW{1'b0}};
            agree_width_const_ff <= `DRVFB_AGREE_RST;
            in_sel_ff <= `DRVFB_IN_SEL_RST;
            out_sel_ff <= `DRVFB_OUT_SEL_RST;
            alloc_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
            // Switch happens on request; a select write restores programming only while the request bit is clear
            if (alloc_req)
                alloc_ff <= 1'b1;
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= `DRVFB_RESP_OK;
                case (awaddr_ff)
                    `DRVFB_CMD_BITS: cmd_ff <= merge(cmd_ff, wdata_ff, wstrb_ff) &
                                               `DRVFB_CMD_MASK;
                    `DRVFB_MON_CODE: monitor_code_word_ff <= wd[FW-1:0];
                    `DRVFB_SET_FREQ: set_freq_word_ff <= wd[FW-1:0];
                    `DRVFB_CMD_CODE: command_code_word_ff <= wd[FW-1:0];
                    `DRVFB_WR_DATA: write_data_word_ff <= wd[FW-1:0];
                    `DRVFB_AGREE_W: agree_width_const_ff <= wd[FW-1:0];
                    `DRVFB_IN_SEL: begin
                        in_sel_ff <= wd[19:0];
                        alloc_ff <= alloc_req;
                    end
                    `DRVFB_OUT_SEL: begin
                        out_sel_ff <= wd[11:0];
                        alloc_ff <= alloc_req;
                    end
                    `DRVFB_STAT_BITS, `DRVFB_MON_DATA, `DRVFB_OUT_FREQ,
                    `DRVFB_RESP_CODE, `DRVFB_RD_DATA, `DRVFB_FREQ_REF: ;
                    default: bresp_ff <= `DRVFB_RESP_SLVERR;
                endcase
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `DRVFB_RESP_OK;
        end else if (rvalid_ff) begin
            if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end else if (s_axi_arvalid) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `DRVFB_RESP_OK;
            rdata_ff <= 32'h0000_0000;
            case (s_axi_araddr)
                `DRVFB_CMD_BITS: rdata_ff <= cmd_ff;
                `DRVFB_STAT_BITS: rdata_ff <= stat_ff;
                `DRVFB_MON_CODE: rdata_ff[FW-1:0] <= monitor_code_word_ff;
                `DRVFB_SET_FREQ: rdata_ff[FW-1:0] <= set_freq_word_ff;
                `DRVFB_CMD_CODE: rdata_ff[FW-1:0] <= command_code_word_ff;
                `DRVFB_WR_DATA: rdata_ff[FW-1:0] <= write_data_word_ff;
                `DRVFB_MON_DATA: rdata_ff[FW-1:0] <= monitor_data_word_ff;
                `DRVFB_OUT_FREQ: rdata_ff[FW-1:0] <= output_freq_i;
                `DRVFB_RESP_CODE: rdata_ff[FW-1:0] <= response_code_word_ff;
                `DRVFB_RD_DATA: rdata_ff[FW-1:0] <= read_data_word_ff;
                `DRVFB_AGREE_W: rdata_ff[FW-1:0] <= agree_width_const_ff;
                `DRVFB_IN_SEL: rdata_ff[19:0] <= in_sel;
                `DRVFB_OUT_SEL: rdata_ff[11:0] <= out_sel;
                `DRVFB_FREQ_REF: rdata_ff[FW-1:0] <= freq_reference_const_ff;
                default: rresp_ff <= `DRVFB_RESP_SLVERR;
            endcase
        end
    end

endmodule

// file: sim/drvfb_assertions.sv
// Purpose: Port-level checks of the fieldbus map
// Assumes: Master offers address and data together
// Notes: Command word is internal, so checks tie outputs together
`timescale 1ns/1ps
module drvfb_chk (
    input wire clk_sys_i,
    input wire rst_i,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire fwd_run_o,
    input wire rev_run_o,
    input wire coast_o,
    input wire nv_store_o,
    input wire cmd_start_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    coast_stops_fwd_a: assert property (coast_o |-> !fwd_run_o)
        else $error("forward run while coasting");
    coast_stops_rev_a: assert property (coast_o |-> !rev_run_o)
        else $error("reverse run while coasting");
    nv_pulse_a: assert property (nv_store_o |=> !nv_store_o)
        else $error("store pulse too long");
    exec_pulse_a: assert property (cmd_start_o |=> !cmd_start_o)
        else $error("start pulse too long");
    wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("no write response");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("no read response");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

// file: sim/drvfb_drive_model.sv
// Purpose: Drive-side model answering store and command pulses
// Assumes: Pulses arrive one cycle wide
// Notes: Data lines show garbage outside the done pulse
`timescale 1ns/1ps
module drvfb_drive_model #(
    parameter DLY = 4
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire nv_store_o,
    input wire cmd_start_o,
    input wire [15:0] cmd_code_o,
    input wire [15:0] cmd_data_o,
    input wire [15:0] monitor_sel_o,
    output logic nv_ack_i,
    output logic cmd_done_i,
    output logic [15:0] cmd_resp_i,
    output logic [15:0] cmd_read_i,
    output wire [15:0] monitor_value_i
);
    int nv_n;
    int ex_n;
    logic [15:0] sum;
    assign sum = cmd_code_o + cmd_data_o;
    assign monitor_value_i = monitor_sel_o ^ 16'h5A5A;
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            nv_n <= 0;
            ex_n <= 0;
            nv_ack_i <= 1'b0;
            cmd_done_i <= 1'b0;
        end else begin
            nv_n <= nv_store_o ? DLY : (nv_n > 0 ? nv_n - 1 : 0);
            ex_n <= cmd_start_o ? DLY : (ex_n > 0 ? ex_n - 1 : 0);
            nv_ack_i <= (nv_n == 1);
            cmd_done_i <= (ex_n == 1);
        end
        // Valid only with the done pulse
        cmd_resp_i <= (ex_n == 1) ? sum : ~sum;
        cmd_read_i <= (ex_n == 1) ? ~cmd_code_o : cmd_code_o;
    end
endmodule

// file: sim/drvfb_top_bench.sv
// Purpose: Self-checking bench of the fieldbus map
// Assumes: Drive model answers store and command pulses
// Notes: Ready handshakes sampled at the falling edge
`timescale 1ns/1ps
module drvfb_top_bench;
    logic clk_sys_i = 0, rst_i = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, v;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic running_fwd_i = 0, running_rev_i = 0, stall_active_i = 0;
    logic drive_fault_i = 0, run_enabled_i = 1;
    logic [15:0] output_freq_i = 16'h1000, nv_freq_i = 16'h1000;
    wire [15:0] monitor_value_i, cmd_resp_i, cmd_read_i, main_freq_o, monitor_sel_o;
    wire [15:0] freq_ref_o, cmd_code_o, cmd_data_o;
    wire nv_ack_i, cmd_done_i, fwd_run_o, rev_run_o, coast_o, fault_reset_o, jog_o;
    wire inch_o, opto_terminal_a_o, opto_terminal_b_o, nv_store_o, cmd_start_o;
    wire [2:0] multi_step_o;
    logic [1:0] rs;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    drvfb_top i_dut (.*);
    drvfb_drive_model i_drv (.*);
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim;
        end
    end
    task chk(input [31:0] s, input [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        logic aw, w, b;
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            @(posedge clk_sys_i);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            n++;
        end while (b !== 1'b1 && n < 50);
        error_cnt += (b !== 1'b1);
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task rd(input [7:0] a);
        logic ar, r;
        int n;
        n = 0;
        @(posedge clk_sys_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk_sys_i);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clk_sys_i);
            if (ar) s_axi_arvalid <= 1'b0;
            n++;
        end while (r !== 1'b1 && n < 50);
        error_cnt += (r !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task rc(input [7:0] a, input [31:0] e);
        rd(a);
        chk(v, e);
    endtask
    // Bounded status poll
    task wbit(input int b, input [31:0] e);
        int n;
        n = 0;
        do begin
            rd(8'h04);
            n++;
        end while (v[b] !== 1'b1 && n < 20);
        chk(v, e);
    endtask
    task t_reset;
        rc(8'h04, 32'h0800_000C);
        rc(8'h28, 32'h0000_00C8);
        rc(8'h2C, 32'h000A_7653);
        rc(8'h30, 32'h0000_001D);
        rc(8'h34, 32'h0000_1000);
        rd(8'h3C);
        chk(rs, 2'b10);
        $display("t_reset done");
    endtask
    task t_run;
        wr(8'h00, 32'h0000_0981);
        rc(8'h00, 32'h0000_0001);
        chk(fwd_run_o, 1'b1);
        running_fwd_i <= 1'b1;
        rc(8'h04, 32'h0800_004D);
        wr(8'h00, 32'h0000_0201);
        chk({coast_o, fwd_run_o}, 2'b10);
        wr(8'h00, 32'h0000_0002);
        chk({coast_o, rev_run_o, fwd_run_o}, 3'b010);
        running_fwd_i <= 1'b0;
        running_rev_i <= 1'b1;
        stall_active_i <= 1'b1;
        rc(8'h04, 32'h0800_005E);
        wr(8'h00, 32'h0000_0000);
        running_rev_i <= 1'b0;
        stall_active_i <= 1'b0;
        chk(rev_run_o, 1'b0);
        $display("t_run done");
    endtask
    task t_fault;
        wr(8'h00, 32'h0000_0401);
        chk({coast_o, fwd_run_o}, 2'b10);
        rc(8'h04, 32'h0400_0088);
        wr(8'h00, 32'h0400_0000);
        wr(8'h00, 32'h0000_0004);
        rc(8'h04, 32'h0400_0088);
        wr(8'h00, 32'h0000_0008);
        chk(fault_reset_o, 1'b1);
        wr(8'h00, 32'h0000_0000);
        rc(8'h04, 32'h0800_000C);
        $display("t_fault done");
    endtask
    task t_freq;
        wr(8'h0C, 32'h0000_1234);
        wr(8'h00, 32'h0000_2000);
        wbit(13, 32'h0800_2004);
        chk(main_freq_o, 16'h1234);
        wr(8'h00, 32'h0000_0000);
        rc(8'h04, 32'h0800_0004);
        wr(8'h0C, 32'h0000_1050);
        wr(8'h00, 32'h0000_4000);
        wbit(14, 32'h0800_400C);
        chk({freq_ref_o, main_freq_o}, 32'h1050_1050);
        wr(8'h00, 32'h0000_0000);
        $display("t_freq done");
    endtask
    task t_exec;
        wr(8'h10, 32'h0000_0042);
        wr(8'h14, 32'h0000_0007);
        wr(8'h00, 32'h0000_8000);
        wbit(15, 32'h0800_800C);
        rc(8'h20, 32'h0000_0049);
        rc(8'h24, 32'h0000_FFBD);
        wr(8'h00, 32'h0000_0000);
        wr(8'h08, 32'h0000_0003);
        wr(8'h00, 32'h0000_1000);
        wbit(12, 32'h0800_100C);
        rc(8'h18, 32'h0000_5A59);
        wr(8'h00, 32'h0000_0000);
        rc(8'h04, 32'h0800_000C);
        $display("t_exec done");
    endtask
    task t_alloc;
        wr(8'h00, 32'h0000_0050);
        chk({multi_step_o, jog_o}, 4'b0011);
        wr(8'h00, 32'h0200_0000);
        wbit(25, 32'h0A00_0008);
        rc(8'h2C, 32'h000B_A876);
        rc(8'h30, 32'h0000_0041);
        wr(8'h00, 32'h0200_0044);
        chk({coast_o, multi_step_o, inch_o}, 5'b00011);
        $display("t_alloc done");
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        t_reset;
        t_run;
        t_fault;
        t_freq;
        t_exec;
        t_alloc;
        end_sim;
    end
endmodule
bind drvfb_top drvfb_chk i_chk (.*);
